// >>> rtl/isol_cfg.svh
// How it works
// - disable low forces all channel outputs off immediately
// - disable low clears shift and latch registers
// - outputs stay off until new word written
// - serial traffic honoured only while select low
// - serial input sampled on serial clock rise
// - serial output changes after serial clock fall
// - serial output driven only while select low
// - serial output carries shifted data for chaining
// - eight bit word, one bit per channel
// - most significant bit shifted in first
// - latch on select rise if clocks a nonzero multiple of eight
// - latched one switches channel on, zero off
`ifndef ISOL_CFG_SVH
`define ISOL_CFG_SVH
`define ISOL_WORD_BITS 8
`define ISOL_FIFO_DEPTH 8
`define ISOL_LATCH_RESET 8'h00
`endif

// >>> rtl/isol_pkg.sv
`include "isol_cfg.svh"
package isol_pkg;
   typedef logic [`ISOL_WORD_BITS-1:0] isol_word_t;
endpackage : isol_pkg

// >>> rtl/isol_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module isol_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   // clocking
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic flush,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
   begin : g_bad_size
      $error("isol_fifo: depth must be a power of two >= 2");
   end
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [WIDTH-1:0] rd_r, rd_nxt;
   logic full, empty, push, pop;
   always_comb
   begin
      full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
      empty = (wp_r == rp_r);
      in_ready = !full;
      out_valid = !empty;
      push = in_valid && !full;
      pop = out_ready && !empty;
      wp_nxt = flush ? '0 : (push ? wp_r + 1'b1 : wp_r);
      rp_nxt = flush ? '0 : (pop ? rp_r + 1'b1 : rp_r);
      // data out of a register, peeks the entry at the next read pointer
      rd_nxt = mem_r[rp_nxt[AW-1:0]];
      if (push && (wp_r[AW-1:0] == rp_nxt[AW-1:0]))
         rd_nxt = in_data;
   end
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         wp_r <= '0;
         rp_r <= '0;
         rd_r <= '0;
      end
      else if (ce)
      begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         rd_r <= rd_nxt;
         if (push)
            mem_r[wp_r[AW-1:0]] <= in_data;
      end
   end
   assign out_data = rd_r;
endmodule : isol_fifo
`default_nettype wire

// >>> rtl/isol_latch.sv
`timescale 1ns/10ps
`default_nettype none
`include "isol_cfg.svh"
module isol_latch
   import isol_pkg::*;
#(
   parameter int WORD_BITS = `ISOL_WORD_BITS,
   parameter int FIFO_DEPTH = `ISOL_FIFO_DEPTH
)
(
   // clocking
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // serial pins
   input wire logic select_n,
   input wire logic sclk,
   input wire logic sdi,
   output logic sdo_o,
   output logic sdo_oe,
   // disable pin, raw asynchronous level
   input wire logic output_disable_n,
   // channel drive
   output logic [WORD_BITS-1:0] channel_outputs,
   output logic word_pending
);
   if (WORD_BITS != 8)
   begin : g_bad_word
      $error("isol_latch: word must be eight bits");
   end
   // two-flop synchronisers
   logic [1:0] cs_s1_r, cs_s1_nxt, ck_s1_r, ck_s1_nxt, di_s1_r, di_s1_nxt, dis_s1_r, dis_s1_nxt;
   logic cs_r, ck_r, di_r, dis_r;
   logic cs_d_r, ck_d_r;
   logic [WORD_BITS-1:0] shift_r, shift_nxt, latch_r, latch_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic any_r, any_nxt;
   logic sdo_r, sdo_nxt;
   logic rise, fall, cs_rise, active;
   logic f_in_valid, f_in_ready, f_out_valid;
   logic [WORD_BITS-1:0] f_out_data;
   always_comb
   begin
      cs_s1_nxt = {cs_s1_r[0], select_n};
      ck_s1_nxt = {ck_s1_r[0], sclk};
      di_s1_nxt = {di_s1_r[0], sdi};
      dis_s1_nxt = {dis_s1_r[0], output_disable_n};
   end
   assign cs_r = cs_s1_r[1];
   assign ck_r = ck_s1_r[1];
   assign di_r = di_s1_r[1];
   assign dis_r = dis_s1_r[1];
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cs_s1_r <= 2'h3;
         ck_s1_r <= 2'h3;
         di_s1_r <= 2'h0;
         dis_s1_r <= 2'h0;
         cs_d_r <= 1'b1;
         ck_d_r <= 1'b1;
      end
      else if (ce)
      begin
         cs_s1_r <= cs_s1_nxt;
         ck_s1_r <= ck_s1_nxt;
         di_s1_r <= di_s1_nxt;
         dis_s1_r <= dis_s1_nxt;
         cs_d_r <= cs_r;
         ck_d_r <= ck_r;
      end
   end
   assign active = !cs_r && !cs_d_r;
   assign rise = active && ck_r && !ck_d_r;
   assign fall = active && !ck_r && ck_d_r;
   assign cs_rise = cs_r && !cs_d_r;
   // shift engine
   always_comb
   begin
      shift_nxt = shift_r;
      cnt_nxt = cnt_r;
      any_nxt = any_r;
      sdo_nxt = sdo_r;
      f_in_valid = 1'b0;
      if (cs_r && cs_d_r)
      begin
         cnt_nxt = 3'h0;
         any_nxt = 1'b0;
      end
      if (rise)
      begin
         shift_nxt = {shift_r[WORD_BITS-2:0], di_r};
         cnt_nxt = cnt_r + 3'h1;
         any_nxt = 1'b1;
      end
      if (fall)
         sdo_nxt = shift_r[WORD_BITS-1];
      if (!cs_r && cs_d_r)
         sdo_nxt = shift_r[WORD_BITS-1];
      if (cs_rise && any_r && cnt_r == 3'h0)
         f_in_valid = 1'b1;
      if (!dis_r)
      begin
         shift_nxt = `ISOL_LATCH_RESET;
         cnt_nxt = 3'h0;
         any_nxt = 1'b0;
         f_in_valid = 1'b0;
      end
   end
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         shift_r <= `ISOL_LATCH_RESET;
         cnt_r <= 3'h0;
         any_r <= 1'b0;
         sdo_r <= 1'b0;
      end
      else if (ce)
      begin
         shift_r <= shift_nxt;
         cnt_r <= cnt_nxt;
         any_r <= any_nxt;
         sdo_r <= sdo_nxt;
      end
   end
   // fifo decouples accepted words from the output latch; one word per frame so it never fills in practice
   isol_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .flush(!dis_r),
      .in_valid(f_in_valid),
      .in_ready(f_in_ready),
      .in_data(shift_r),
      .out_valid(f_out_valid),
      .out_ready(1'b1),
      .out_data(f_out_data)
   );
   always_comb
   begin
      latch_nxt = latch_r;
      if (f_out_valid)
         latch_nxt = f_out_data;
      if (!dis_r)
         latch_nxt = `ISOL_LATCH_RESET;
   end
   always_ff @(posedge clk)
   begin
      if (reset)
         latch_r <= `ISOL_LATCH_RESET;
      else if (ce)
         latch_r <= latch_nxt;
   end
   // raw pin gates the drive so disable acts without any clock
   assign channel_outputs = output_disable_n ? latch_r : '0;
   assign sdo_o = sdo_r;
   assign sdo_oe = !cs_r;
   assign word_pending = f_out_valid || !f_in_ready;
   a_disable_off: assert property (@(posedge clk) disable iff (reset)
      !output_disable_n |-> channel_outputs == 8'h00) else $error("outputs on while disabled");
   a_disable_clear: assert property (@(posedge clk) disable iff (reset)
      (ce && !dis_r) |=> (latch_r == 8'h00 && shift_r == 8'h00)) else $error("registers not cleared");
   a_stay_off: assert property (@(posedge clk) disable iff (reset)
      (ce && latch_r == 8'h00 && !f_out_valid) |=> latch_r == 8'h00) else $error("latch changed without word");
   a_idle_ignore: assert property (@(posedge clk) disable iff (reset)
      (ce && cs_r && cs_d_r && dis_r) |=> $stable(shift_r)) else $error("shift moved while deselected");
   a_sample_rise: assert property (@(posedge clk) disable iff (reset)
      (ce && rise && dis_r) |=> shift_r[0] == $past(di_r)) else $error("input not sampled");
   a_out_fall: assert property (@(posedge clk) disable iff (reset)
      (ce && !fall && cs_d_r == cs_r) |=> $stable(sdo_r)) else $error("sdo moved off a fall");
   // judged against the pin two samples back, not against the sync flop
   a_oe_sel: assert property (@(posedge clk) disable iff (reset)
      ($past(ce) && $past(ce, 2) && !$past(reset) && !$past(reset, 2)) |-> sdo_oe == !$past(select_n, 2))
      else $error("sdo driven while deselected");
   a_mod_eight: assert property (@(posedge clk) disable iff (reset)
      f_in_valid |-> (cnt_r == 3'h0 && cs_rise)) else $error("word taken on bad count");
endmodule : isol_latch
`default_nettype wire

// >>> tb/isol_host.sv
`timescale 1ns/10ps
`default_nettype none
module isol_host
(
   // clocking
   input wire logic clk,
   // serial pins
   output logic select_n,
   output logic sclk,
   output logic sdi,
   input wire logic sdo_o,
   input wire logic sdo_oe
);
   logic [15:0] rx;
   initial
   begin
      select_n = 1'b1;
      sclk = 1'b1;
      sdi = 1'b0;
      rx = 16'h0000;
   end
   // sclk stays high across both select edges
   // sclk edges sit 1.25 ns off the clk edges and select edges on falling clk edges, so none meets a rising clk edge
   task automatic frame(input logic [15:0] w, input int n);
      @(negedge clk);
      select_n = 1'b0;
      #126.25;
      for (int i = n - 1; i >= 0; i--)
      begin
         sclk = 1'b0;
         sdi = w[i];
         #62.5;
         rx = {rx[14:0], sdo_oe ? sdo_o : 1'bx};
         sclk = 1'b1;
         #62.5;
      end
      @(negedge clk);
      repeat (12) @(negedge clk);
      select_n = 1'b1;
      // released line must not keep its last value
      sdi = ~sdi;
      repeat (25) @(negedge clk);
   endtask : frame
   // clocks sent while deselected
   task automatic stray(input int n);
      @(negedge clk);
      #1.25;
      for (int i = 0; i < n; i++)
      begin
         sclk = 1'b0;
         sdi = ~sdi;
         #62.5;
         sclk = 1'b1;
         #62.5;
      end
      @(negedge clk);
   endtask : stray
endmodule : isol_host
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
   import isol_pkg::*;
   logic clk, reset, ce, select_n, sclk, sdi, sdo_o, sdo_oe, output_disable_n;
   isol_word_t channel_outputs;
   logic word_pending;
   logic wp_seen = 1'b0;
   int n_words = 0;
   int n_fail = 0;
   int checks_done = 0;
   always #5 clk = ~clk;
   // one word_pending pulse per accepted word
   always @(negedge clk)
   begin
      if (word_pending === 1'b1 && !wp_seen)
         n_words++;
      wp_seen = (word_pending === 1'b1);
   end
   isol_host isol_host_inst (.clk(clk), .select_n(select_n), .sclk(sclk), .sdi(sdi), .sdo_o(sdo_o),
      .sdo_oe(sdo_oe));
   isol_latch isol_latch_inst (.clk(clk), .reset(reset), .ce(ce), .select_n(select_n), .sclk(sclk),
      .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .output_disable_n(output_disable_n),
      .channel_outputs(channel_outputs), .word_pending(word_pending));
   task automatic end_sim;
      if (n_fail == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   task automatic wait_out(input isol_word_t e);
      int k;
      for (k = 0; k < 50 && channel_outputs !== e; k++)
         @(negedge clk);
      if (k == 50)
      begin
         n_fail++;
         end_sim();
      end
      `CHK("channels", e, channel_outputs)
   endtask : wait_out
   task automatic t_word;
      fork
         isol_host_inst.frame(16'h00a5, 8);
         begin
            #400;
            `CHK("sdo_oe on", 1'b1, sdo_oe)
         end
      join
      wait_out(8'ha5);
      `CHK("sdo_oe off", 1'b0, sdo_oe)
      `CHK("words", 1, n_words)
   endtask : t_word
   task automatic t_daisy;
      isol_host_inst.frame(16'h5a3c, 16);
      wait_out(8'h3c);
      `CHK("sdo chain", 16'ha55a, isol_host_inst.rx)
      `CHK("words", 2, n_words)
   endtask : t_daisy
   task automatic t_bad;
      isol_host_inst.frame(16'h01ff, 0);
      isol_host_inst.frame(16'h01ff, 7);
      isol_host_inst.frame(16'h01ff, 9);
      isol_host_inst.stray(8);
      // frozen block must let a whole frame pass unseen
      @(negedge clk);
      ce = 1'b0;
      isol_host_inst.frame(16'h0077, 8);
      ce = 1'b1;
      repeat (20) @(negedge clk);
      `CHK("dropped", 8'h3c, channel_outputs)
      `CHK("words", 2, n_words)
   endtask : t_bad
   task automatic t_dis;
      @(negedge clk);
      output_disable_n = 1'b0;
      #1;
      `CHK("disable", 8'h00, channel_outputs)
      repeat (5) @(negedge clk);
      output_disable_n = 1'b1;
      repeat (30) @(negedge clk);
      `CHK("after disable", 8'h00, channel_outputs)
      fork
         isol_host_inst.frame(16'h00ff, 8);
         begin
            #100;
            `CHK("sdo cleared", 1'b0, sdo_o)
         end
      join
      wait_out(8'hff);
      `CHK("words", 3, n_words)
   endtask : t_dis
   initial
   begin
      clk = 1'b0;
      reset = 1'b1;
      ce = 1'b1;
      output_disable_n = 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      repeat (5) @(negedge clk);
      `CHK("reset out", 8'h00, channel_outputs)
      t_word();
      t_daisy();
      t_bad();
      t_dis();
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
